// *** common/bst_pkg.sv ***
// Constants, opcodes and state types for the boundary-scan test access port.
// Assumes the tester clocks the port on its own test clock, which is unrelated to sys_clk_in.
// How it works
// - Standard TAP state machine stepped by mode select
// - Four test pins, instruction and data registers
// - Mode select and data in taken on rising edge
// - Data out changes on falling test clock edge
// - Test pins act only while test select asserted
// - 16-bit instruction; zeros/ones bypass, FFF8 sample
// - Decode extest, clamp, idcode, highz, private select
// - Fixed 32-bit identification code shifted under idcode
// - Every digital pin has a scan cell
// - No scan cells for analog or crystal pins
package bst_pkg;
    localparam int IR_W = 16;
    localparam int ID_W = 32;
    localparam logic [IR_W-1:0] OP_BYPASS0 = 16'h0000;
    localparam logic [IR_W-1:0] OP_BYPASS1 = 16'hFFFF;
    localparam logic [IR_W-1:0] OP_SAMPLE = 16'hFFF8;
    localparam logic [IR_W-1:0] OP_EXTEST = 16'hFFE8;
    localparam logic [IR_W-1:0] OP_CLAMP = 16'hFFEF;
    localparam logic [IR_W-1:0] OP_IDCODE = 16'hFFFE;
    localparam logic [IR_W-1:0] OP_HIGHZ = 16'hFFCF;
    localparam logic [IR_W-1:0] OP_INT_SEL = 16'hFFFD;
    // Value loaded into the instruction shifter on capture; low bits 01 as the standard asks
    localparam logic [IR_W-1:0] IR_CAPTURE = 16'h0001;
    // Identification word; the value is arbitrary, bit 0 must stay one
    localparam logic [ID_W-1:0] ID_CODE_DEFAULT = 32'h0ABC_D001;
    localparam logic BYP_CAPTURE = 1'b0;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
    } bst_tap_e;

    typedef enum logic [1:0] {
        SEL_BYPASS, SEL_BSR, SEL_ID, SEL_INT
    } bst_sel_e;
endpackage

// *** src/bst_sync.sv ***
// Two-flop level synchroniser, vector wide.
// Assumes each bit is an independent level; no bus coherence is promised.
`timescale 1ns/1ps
module bst_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } bst_sync_s;

    bst_sync_s st;
    bst_sync_s next_st;

    // First stage feeds only the second stage
    always_comb
    begin
        next_st.s1 = d_in;
        next_st.s2 = st.s1;
    end

    // Synchronous reset clears both stages
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
            st <= '0;
        else
            st <= next_st;
    end

    assign q_out = st.s2;
endmodule // bst_sync

// *** src/bst_tap.sv ***
// Boundary-scan test access port with scan chain over the digital pins.
// Assumes tck_in is a free clock port from the tester; pads and core signals are foreign to it.
`timescale 1ns/1ps
module bst_tap
    import bst_pkg::*;
#(
    parameter int NUM_PINS = 8,
    parameter int INT_W = 8,
    parameter logic [ID_W-1:0] ID_CODE = ID_CODE_DEFAULT
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic test_mode_pin_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    output logic tdo_out,
    output logic tdo_oe_n_out,
    input wire logic [NUM_PINS-1:0] core_out_in,
    input wire logic [NUM_PINS-1:0] core_oe_n_in,
    input wire logic [NUM_PINS-1:0] pad_in,
    output logic [NUM_PINS-1:0] pad_out,
    output logic [NUM_PINS-1:0] pad_oe_n_out,
    output logic test_port_active_out,
    output logic internal_select_out,
    output logic [INT_W-1:0] internal_dr_out
);
    // Chain layout: inputs low, output data middle, output enables high
    localparam int BSR_LEN = 3 * NUM_PINS;

    typedef struct packed {
        bst_tap_e state;
        logic [IR_W-1:0] ir_sr;
        logic [IR_W-1:0] ir;
        logic byp;
        logic [ID_W-1:0] id_sr;
        logic [BSR_LEN-1:0] bsr_sr;
        logic [BSR_LEN-1:0] bsr_upd;
        logic [INT_W-1:0] int_sr;
        logic [INT_W-1:0] int_upd;
        logic int_flag;
    } bst_tck_s;

    typedef struct packed {
        logic tdo;
        logic drive;
    } bst_neg_s;

    function automatic bst_sel_e sel_of(input logic [IR_W-1:0] op);
        case (op)
            OP_SAMPLE, OP_EXTEST, OP_HIGHZ: sel_of = SEL_BSR;
            OP_IDCODE: sel_of = SEL_ID;
            OP_INT_SEL: sel_of = SEL_INT;
            default: sel_of = SEL_BYPASS;
        endcase
    endfunction

    function automatic bst_tap_e tap_next(input bst_tap_e s, input logic tms);
        case (s)
            ST_RESET: tap_next = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: tap_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tap_next = tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR: tap_next = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: tap_next = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: tap_next = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: tap_next = tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR: tap_next = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: tap_next = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: tap_next = tms ? ST_SEL_DR : ST_IDLE;
            default: tap_next = ST_RESET;
        endcase
    endfunction

    logic tm_tck;
    logic [BSR_LEN-1:0] pins_sync;
    bst_tck_s st;
    bst_tck_s next_st;
    bst_neg_s ng;
    bst_neg_s next_ng;
    bst_sel_e sel;
    logic dr_lsb;
    logic shifting;

    // Test select seen in both domains; in the link domain it doubles as the TAP reset
    bst_sync #(.WIDTH(1)) u_tm_tck (
        .clk_in(tck_in),
        .nrst_in(nrst_in),
        .d_in(test_mode_pin_in),
        .q_out(tm_tck)
    );

    bst_sync #(.WIDTH(1)) u_tm_sys (
        .clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .d_in(test_mode_pin_in),
        .q_out(test_port_active_out)
    );

    // Private select flag handed to the core domain as a level; taken from a flop so no decode glitch crosses
    bst_sync #(.WIDTH(1)) u_int_sys (
        .clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .d_in(st.int_flag),
        .q_out(internal_select_out)
    );

    // Pad and core levels cross into the link domain before capture
    bst_sync #(.WIDTH(BSR_LEN)) u_pins (
        .clk_in(tck_in),
        .nrst_in(nrst_in),
        .d_in({core_oe_n_in, core_out_in, pad_in}),
        .q_out(pins_sync)
    );

    assign sel = sel_of(st.ir);

    // Serial data path, rising edge of the test clock
    always_comb
    begin
        next_st = st;
        next_st.state = tap_next(st.state, tms_in);
        case (st.state)
            ST_CAP_IR: next_st.ir_sr = IR_CAPTURE;
            ST_SH_IR: next_st.ir_sr = {tdi_in, st.ir_sr[IR_W-1:1]};
            ST_UPD_IR: next_st.ir = st.ir_sr;
            ST_CAP_DR:
            begin
                case (sel)
                    SEL_BSR: next_st.bsr_sr = pins_sync;
                    SEL_ID: next_st.id_sr = ID_CODE;
                    SEL_INT: next_st.int_sr = st.int_upd;
                    default: next_st.byp = BYP_CAPTURE;
                endcase
            end
            ST_SH_DR:
            begin
                case (sel)
                    SEL_BSR: next_st.bsr_sr = {tdi_in, st.bsr_sr[BSR_LEN-1:1]};
                    SEL_ID: next_st.id_sr = {tdi_in, st.id_sr[ID_W-1:1]};
                    SEL_INT: next_st.int_sr = {tdi_in, st.int_sr[INT_W-1:1]};
                    default: next_st.byp = tdi_in;
                endcase
            end
            ST_UPD_DR:
            begin
                if (sel == SEL_BSR)
                    next_st.bsr_upd = st.bsr_sr;
                if (sel == SEL_INT)
                    next_st.int_upd = st.int_sr;
            end
            default: next_st.ir = st.ir;
        endcase
        // Any path into reset reloads the identification instruction
        if (next_st.state == ST_RESET)
            next_st.ir = OP_IDCODE;
        // Decoded once here and registered, so the crossing sees one clean level
        next_st.int_flag = (next_st.ir == OP_INT_SEL);
    end

    // Test select low holds the TAP in reset, so the pins stay functional
    always_ff @(posedge tck_in)
    begin
        if (!tm_tck)
        begin
            st <= '0;
            st.state <= ST_RESET;
            st.ir <= OP_IDCODE;
        end
        else
            st <= next_st;
    end

    always_comb
    begin
        case (sel)
            SEL_BSR: dr_lsb = st.bsr_sr[0];
            SEL_ID: dr_lsb = st.id_sr[0];
            SEL_INT: dr_lsb = st.int_sr[0];
            default: dr_lsb = st.byp;
        endcase
    end

    assign shifting = (st.state == ST_SH_DR) || (st.state == ST_SH_IR);

    // Output flop on the falling edge gives the tester half a period of margin
    always_comb
    begin
        next_ng.drive = shifting;
        next_ng.tdo = (st.state == ST_SH_IR) ? st.ir_sr[0] : dr_lsb;
    end

    always_ff @(negedge tck_in)
    begin
        if (!tm_tck)
            ng <= '0;
        else
            ng <= next_ng;
    end

    assign tdo_out = ng.tdo;
    assign tdo_oe_n_out = !(ng.drive && tm_tck);
    assign internal_dr_out = st.int_upd;

    // Pin multiplex: extest and clamp drive the update cells, highz floats every output
    always_comb
    begin
        pad_out = core_out_in;
        pad_oe_n_out = core_oe_n_in;
        if (st.ir == OP_EXTEST || st.ir == OP_CLAMP)
        begin
            pad_out = st.bsr_upd[2*NUM_PINS-1:NUM_PINS];
            pad_oe_n_out = st.bsr_upd[BSR_LEN-1:2*NUM_PINS];
        end
        else if (st.ir == OP_HIGHZ)
            pad_oe_n_out = '1;
    end

    property p_tms_reset;
        @(posedge tck_in) disable iff (!tm_tck) tms_in [*5] |=> st.state == ST_RESET;
    endproperty
    a_tms_reset: assert property (p_tms_reset) else $error("five TMS highs did not reach reset");

    property p_reset_idcode;
        @(posedge tck_in) disable iff (!tm_tck) st.state == ST_RESET |-> st.ir == OP_IDCODE;
    endproperty
    a_reset_idcode: assert property (p_reset_idcode) else $error("reset state without idcode");

    property p_ir_shift;
        @(posedge tck_in) disable iff (!tm_tck)
            st.state == ST_SH_IR |=> st.ir_sr == {$past(tdi_in), $past(st.ir_sr[IR_W-1:1])};
    endproperty
    a_ir_shift: assert property (p_ir_shift) else $error("instruction shift wrong");

    property p_bypass_codes;
        @(posedge tck_in) disable iff (!tm_tck)
            st.state == ST_UPD_IR && (st.ir_sr == OP_BYPASS0 || st.ir_sr == OP_BYPASS1) |=> sel == SEL_BYPASS;
    endproperty
    a_bypass_codes: assert property (p_bypass_codes) else $error("bypass code not decoded");

    property p_unknown_bypass;
        @(posedge tck_in) disable iff (!tm_tck)
            st.state == ST_UPD_IR && st.ir_sr == 16'h1234 |=> sel == SEL_BYPASS;
    endproperty
    a_unknown_bypass: assert property (p_unknown_bypass) else $error("unlisted code not bypass");

    property p_id_capture;
        @(posedge tck_in) disable iff (!tm_tck)
            st.state == ST_CAP_DR && st.ir == OP_IDCODE |=> st.id_sr == ID_CODE;
    endproperty
    a_id_capture: assert property (p_id_capture) else $error("id code not captured");

    property p_sample_capture;
        @(posedge tck_in) disable iff (!tm_tck)
            st.state == ST_CAP_DR && st.ir == OP_SAMPLE |=> st.bsr_sr == $past(pins_sync);
    endproperty
    a_sample_capture: assert property (p_sample_capture) else $error("pins not sampled");

    property p_highz;
        @(posedge tck_in) disable iff (!tm_tck) st.ir == OP_HIGHZ |-> pad_oe_n_out == '1;
    endproperty
    a_highz: assert property (p_highz) else $error("highz left a pin driven");

    property p_tdo_dr;
        @(posedge tck_in) disable iff (!tm_tck)
            st.state == ST_SH_DR && $past(st.state) == ST_SH_DR |-> tdo_out == dr_lsb && !tdo_oe_n_out;
    endproperty
    a_tdo_dr: assert property (p_tdo_dr) else $error("data out not presented at falling edge");

    c_id_scan: cover property (@(posedge tck_in) st.state == ST_SH_DR && sel == SEL_ID);
    c_extest: cover property (@(posedge tck_in) st.state == ST_UPD_DR && st.ir == OP_EXTEST);
    c_int_sel: cover property (@(posedge tck_in) st.state == ST_UPD_DR && sel == SEL_INT);
    c_bypass: cover property (@(posedge tck_in) st.state == ST_SH_DR && sel == SEL_BYPASS);
endmodule // bst_tap

// *** tb/bst_tap_bench.sv ***
// Self-checking bench for the boundary-scan port.
// Assumes default parameters: eight pins, eight-bit private register.
`timescale 1ns/1ps
module bst_tap_bench
    import bst_pkg::*;
;
    logic sys_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic test_mode_pin_in = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe_n, port_act, int_sel;
    logic [7:0] core_out = 8'hC3;
    logic [7:0] core_oe_n = 8'h5A;
    logic [7:0] pad_in = 8'h96;
    logic [7:0] pad_out, pad_oe_n, int_dr;
    logic [31:0] d;
    int fails = 0;
    int n_tests = 0;

    always #12.5 sys_clk_in = ~sys_clk_in;

    bst_tap dut_u (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .test_mode_pin_in(test_mode_pin_in),
        .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n),
        .core_out_in(core_out), .core_oe_n_in(core_oe_n), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_n_out(pad_oe_n), .test_port_active_out(port_act), .internal_select_out(int_sel),
        .internal_dr_out(int_dr));
    bst_tester tester_u (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo), .tdo_oe_n_in(tdo_oe_n));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got %08h exp %08h", $time, got, exp);
        end
    endtask

    // Instruction capture pattern comes back on every load
    task automatic load_ir(input logic [15:0] code);
        tester_u.scan(1'b1, 16, {16'h0000, code}, d);
        chk(d, 32'h0000_0001);
    endtask

    task automatic t_idcode();
        tester_u.tlr();
        chk(port_act, 1'b1);
        tester_u.scan(1'b0, 32, 32'h0, d);
        chk(d, ID_CODE_DEFAULT);
        // Second walk to reset from idle, then the same word by explicit load
        tester_u.tlr();
        load_ir(OP_IDCODE);
        tester_u.scan(1'b0, 32, 32'hFFFF_FFFF, d);
        chk(d, ID_CODE_DEFAULT);
        $display("idcode test done");
    endtask

    // Bypass delays by one bit and captures zero
    task automatic t_bypass();
        logic [15:0] codes [3] = '{OP_BYPASS0, OP_BYPASS1, 16'h1234};
        foreach (codes[i])
        begin
            load_ir(codes[i]);
            tester_u.scan(1'b0, 8, 32'hB5, d);
            chk(d, 32'h6A);
        end
        $display("bypass test done");
    endtask

    // 32 bits through a 24-cell chain: the tail shows what went in
    task automatic t_chain();
        load_ir(OP_SAMPLE);
        tester_u.scan(1'b0, 32, 32'h0FA5_33E7, d);
        chk(d, 32'hE75A_C396);
        chk({pad_oe_n, pad_out}, 16'h5AC3);
        load_ir(OP_EXTEST);
        chk({pad_oe_n, pad_out}, 16'h0FA5);
        load_ir(OP_CLAMP);
        chk({pad_oe_n, pad_out}, 16'h0FA5);
        tester_u.scan(1'b0, 8, 32'hB5, d);
        chk(d, 32'h6A);
        load_ir(OP_HIGHZ);
        chk(pad_oe_n, 8'hFF);
        $display("chain test done");
    endtask

    task automatic t_private();
        load_ir(OP_INT_SEL);
        repeat (8) @(negedge sys_clk_in);
        chk(int_sel, 1'b1);
        tester_u.scan(1'b0, 8, 32'hA5, d);
        chk(d, 32'h0);
        chk(int_dr, 8'hA5);
        tester_u.scan(1'b0, 8, 32'h3C, d);
        chk(d, 32'hA5);
        $display("private test done");
    endtask

    // Dropping test select hands the pins back
    task automatic t_exit();
        @(negedge sys_clk_in);
        test_mode_pin_in = 1'b0;
        tester_u.pulses(4);
        repeat (8) @(negedge sys_clk_in);
        chk({port_act, tdo_oe_n, pad_oe_n, pad_out}, 18'h15AC3);
        chk(int_sel, 1'b0);
        chk(tester_u.bad_edges, 0);
        $display("exit test done");
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Whole run is near 51 us; a hang stops here
    initial
    begin
        #400000;
        fails++;
        print_verdict();
    end

    initial
    begin
        fork
            repeat (16) @(posedge sys_clk_in);
            tester_u.pulses(3);
        join
        @(negedge sys_clk_in);
        nrst_in = 1'b1;
        test_mode_pin_in = 1'b1;
        t_idcode();
        t_bypass();
        t_chain();
        t_private();
        t_exit();
        print_verdict();
    end
endmodule // bst_tap_bench

// *** tb/bst_tester.sv ***
// Behavioural test-port tester: makes the test clock only while one of its tasks runs.
// Assumes the bench calls its tasks one at a time from a single process.
`timescale 1ns/1ps
module bst_tester (
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    input wire logic tdo_in,
    input wire logic tdo_oe_n_in
);
    int bad_edges = 0;
    initial
    begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end

    // One clock: inputs move while low, data out taken at the rise
    task automatic step(input logic tms_v, input logic tdi_v, input logic shifting, output logic tdo_v);
        logic raw;
        tms_out = tms_v;
        tdi_out = tdi_v;
        #62.5;
        tck_out = 1'b1;
        raw = tdo_in;
        // A released data out line reads as the inverse, so an undriven bit can never pass
        tdo_v = (tdo_oe_n_in === 1'b0) ? raw : ~raw;
        if (shifting && tdo_oe_n_in !== 1'b0)
            bad_edges++;
        #62;
        if (tdo_in !== raw) // Data out may only move on the fall
            bad_edges++;
        #0.5;
        tck_out = 1'b0;
    endtask

    // Idle steps toggle data in, so a stale bit can never look valid
    task automatic pulses(input int k);
        logic d;
        repeat (k) step(1'b1, ~tdi_out, 1'b0, d);
    endtask

    // Five ones reach reset whatever the state, then one zero to idle
    task automatic tlr();
        logic d;
        pulses(5);
        step(1'b0, ~tdi_out, 1'b0, d);
    endtask

    // Full scan from idle back to idle, bit 0 first
    task automatic scan(input logic is_ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic d;
        dout = '0;
        pulses(is_ir ? 2 : 1);
        step(1'b0, ~tdi_out, 1'b0, d);
        step(1'b0, ~tdi_out, 1'b0, d);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], 1'b1, d);
            dout[i] = d;
        end
        pulses(1);
        step(1'b0, ~tdi_out, 1'b0, d);
    endtask
endmodule // bst_tester
